// ---- common/gfb_pkg.sv ----
// constants and types shared by the group fault broadcast block
package gfb_pkg;
  // group bus message kinds
  localparam logic [1:0] GB_KIND_OPERATION = 2'h0;
  localparam logic [1:0] GB_KIND_VOUT = 2'h1;
  localparam logic [1:0] GB_KIND_FAULT = 2'h2;
  // over-temperature response encodings
  localparam logic OT_RESP_LATCHED = 1'h0;
  localparam logic OT_RESP_AUTO = 1'h1;
  localparam logic OT_RESP_RESET = OT_RESP_LATCHED;
  // field widths and positions
  localparam int GROUP_ID_W = 5;
  localparam int PM_ADDR_W = 7;
  localparam int OP_ON_BIT = 7;
  // reset values
  localparam logic CMD_ON_RESET = 1'h0;
  localparam logic [15:0] CMD_DATA_RESET = 16'h0000;
  // restart slot per sequence position
  localparam int CLK_PERIOD_NS = 10;
  localparam int SLOT_TIME_NS = 1000;
  localparam int SLOT_CYCLES =
    (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // restart sequencer states
  typedef enum logic [0:0] {
    GFB_RS_IDLE = 1'b0,
    GFB_RS_WAIT = 1'b1
  } gfb_rs_state_t;
endpackage : gfb_pkg

// ---- verilog/gfb_otp.sv ----
// over-temperature monitor with latched or hysteretic response
`timescale 1ns/10ps
module gfb_otp
#(
  parameter int TW = 16
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [TW-1:0] t_ctrl,
  input wire logic [TW-1:0] t_ps_a,
  input wire logic [TW-1:0] t_ps_b,
  input wire logic [TW-1:0] fault_limit,
  input wire logic [TW-1:0] warn_limit,
  input wire logic resp_auto,
  input wire logic clear_faults,
  input wire logic enable_rise,
  output logic ot_off,
  output logic [TW-1:0] temp1,
  output logic [TW-1:0] temp3
);
  logic over; // any sensor above fault limit
  logic below; // all sensors under warn limit
  logic [TW-1:0] ps_max; // hotter power stage
  logic next_ot_off;
  logic [TW-1:0] next_temp1;
  logic [TW-1:0] next_temp3;

  // compare and response selection
  always_comb
  begin
    ps_max = (t_ps_a > t_ps_b) ? t_ps_a : t_ps_b;
    over = (t_ctrl > fault_limit) || (ps_max > fault_limit);
    below = (t_ctrl < warn_limit) && (ps_max < warn_limit);
    next_temp1 = t_ctrl;
    next_temp3 = ps_max;
    next_ot_off = ot_off;
    if (over)
    begin
      next_ot_off = 1'b1;
    end
    else if (resp_auto)
    begin
      if (below)
      begin
        next_ot_off = 1'b0;
      end
    end
    else if (clear_faults || enable_rise)
    begin
      next_ot_off = 1'b0;
    end
  end

  // register stage
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      ot_off <= 1'b0;
      temp1 <= '0;
      temp3 <= '0;
    end
    else if (clk_en)
    begin
      ot_off <= next_ot_off;
      temp1 <= next_temp1;
      temp3 <= next_temp3;
    end
  end

  property p_ot_trip;
    @(posedge clock) disable iff (!nrst)
    (clk_en && over) |=> ot_off;
  endproperty
  a_ot_trip: assert property (p_ot_trip)
    else $error("over-temperature did not shut output");

  property p_latch_hold;
    @(posedge clock) disable iff (!nrst)
    (clk_en && ot_off && !resp_auto && !clear_faults && !enable_rise)
      |=> ot_off;
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latched over-temperature released early");

  property p_auto_resume;
    @(posedge clock) disable iff (!nrst)
    (clk_en && resp_auto && below && !over) |=> !ot_off;
  endproperty
  a_auto_resume: assert property (p_auto_resume)
    else $error("auto restart did not resume below warn");

  property p_temp3;
    @(posedge clock) disable iff (!nrst)
    clk_en |=> (temp3 == $past(ps_max)) && (temp1 == $past(t_ctrl));
  endproperty
  a_temp3: assert property (p_temp3)
    else $error("temperature readback wrong");
endmodule : gfb_otp

// ---- verilog/gfb_top.sv ----
// group broadcast, fault spreading and over-temperature supervisor
`timescale 1ns/10ps
// Contract
// - forward local operation and vout commands
// - execute accepted broadcasts as local commands
// - broadcast send and accept have enables
// - local fault shuts output and sends event
// - follow peer fault events when enabled
// - restart after spread fault by position
// - fault spreading set by both configs
// - compare three temperatures against fault limit
// - latched trip holds until clear or enable
// - auto trip resumes below warn limit
// - response selection resets to latched
// - limits and response are host programmable
// - current sharing forces latched response
// - report controller and hotter stage temperature
// - group id defaults to address low bits
module gfb_top
#(
  parameter int TW = 16,
  parameter int SLOT = gfb_pkg::SLOT_CYCLES
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  // decoded host commands
  input wire logic pm_cmd_valid,
  input wire logic pm_cmd_is_vout,
  input wire logic [15:0] pm_cmd_data,
  input wire logic clear_faults,
  // group_broadcast_config bits
  input wire logic bcast_send_en,
  input wire logic bcast_accept_en,
  input wire logic fault_send_en,
  input wire logic fault_follow_en,
  // fault_group_config bits
  input wire logic restart_en,
  input wire logic [3:0] seq_position,
  // group_id_config
  input wire logic [gfb_pkg::PM_ADDR_W-1:0] pm_addr,
  input wire logic group_id_override,
  input wire logic [gfb_pkg::GROUP_ID_W-1:0] group_id_value,
  output logic [gfb_pkg::GROUP_ID_W-1:0] group_id,
  // fault input
  input wire logic nd_fault,
  input wire logic shutdown_on_fault,
  input wire logic current_share,
  // over-temperature settings
  input wire logic [TW-1:0] ot_fault_limit,
  input wire logic [TW-1:0] ot_warn_limit,
  input wire logic ot_resp_wr,
  input wire logic ot_resp_in,
  input wire logic [TW-1:0] t_ctrl,
  input wire logic [TW-1:0] t_ps_a,
  input wire logic [TW-1:0] t_ps_b,
  output logic ot_resp_sel,
  output logic [TW-1:0] temp1,
  output logic [TW-1:0] temp3,
  // group bus message port
  output logic gb_tx_valid,
  input wire logic gb_tx_ready,
  output logic [1:0] gb_tx_kind,
  output logic [gfb_pkg::GROUP_ID_W-1:0] gb_tx_id,
  output logic [15:0] gb_tx_data,
  input wire logic gb_rx_valid,
  input wire logic [1:0] gb_rx_kind,
  input wire logic [gfb_pkg::GROUP_ID_W-1:0] gb_rx_id,
  input wire logic [15:0] gb_rx_data,
  // local execution and output state
  output logic exec_valid,
  output logic exec_is_vout,
  output logic [15:0] exec_data,
  output logic output_on,
  output logic fault_off
);
  // matches an incoming message against our rail id
  function automatic logic id_hit(
    input logic [gfb_pkg::GROUP_ID_W-1:0] a,
    input logic [gfb_pkg::GROUP_ID_W-1:0] b);
    id_hit = (a == b);
  endfunction : id_hit

  logic rx_cmd; // accepted broadcast command
  logic rx_fault; // accepted peer fault
  logic loc_fault; // local shutdown fault
  logic tx_busy_fault; // fault message still waiting
  logic do_exec; // a command executes this cycle
  logic ex_vout;
  logic [15:0] ex_data;
  logic enable_rise; // output being re-enabled
  logic ot_off; // over-temperature shutdown
  logic resp_auto_eff; // effective response
  logic cmd_on; // commanded on state
  gfb_pkg::gfb_rs_state_t rs_state;
  logic [15:0] rs_count; // restart slot countdown
  logic next_gb_tx_valid;
  logic [1:0] next_gb_tx_kind;
  logic [15:0] next_gb_tx_data;
  logic next_exec_valid;
  logic next_exec_is_vout;
  logic [15:0] next_exec_data;
  logic next_cmd_on;
  logic next_output_on;
  logic next_fault_off;
  logic next_ot_resp_sel;
  gfb_pkg::gfb_rs_state_t next_rs_state;
  logic [15:0] next_rs_count;

  // rail id and message classification
  always_comb
  begin
    group_id = group_id_override ? group_id_value :
      pm_addr[gfb_pkg::GROUP_ID_W-1:0];
    rx_cmd = gb_rx_valid && bcast_accept_en &&
      id_hit(gb_rx_id, group_id) &&
      (gb_rx_kind != gfb_pkg::GB_KIND_FAULT);
    rx_fault = gb_rx_valid && fault_follow_en &&
      id_hit(gb_rx_id, group_id) &&
      (gb_rx_kind == gfb_pkg::GB_KIND_FAULT);
    loc_fault = nd_fault && shutdown_on_fault;
    tx_busy_fault = gb_tx_valid && !gb_tx_ready &&
      (gb_tx_kind == gfb_pkg::GB_KIND_FAULT);
    resp_auto_eff = ot_resp_sel && !current_share;
  end

  // group bus transmit slot, fault first
  always_comb
  begin
    next_gb_tx_valid = gb_tx_valid && !gb_tx_ready;
    next_gb_tx_kind = gb_tx_kind;
    next_gb_tx_data = gb_tx_data;
    if (loc_fault && fault_send_en)
    begin
      next_gb_tx_valid = 1'b1;
      next_gb_tx_kind = gfb_pkg::GB_KIND_FAULT;
      next_gb_tx_data = 16'h0000;
    end
    else if (pm_cmd_valid && bcast_send_en && !tx_busy_fault)
    begin
      next_gb_tx_valid = 1'b1;
      next_gb_tx_kind = pm_cmd_is_vout ? gfb_pkg::GB_KIND_VOUT :
        gfb_pkg::GB_KIND_OPERATION;
      next_gb_tx_data = pm_cmd_data;
    end
  end

  // local command execution, host before group bus
  always_comb
  begin
    do_exec = pm_cmd_valid || rx_cmd;
    ex_vout = pm_cmd_valid ? pm_cmd_is_vout :
      (gb_rx_kind == gfb_pkg::GB_KIND_VOUT);
    ex_data = pm_cmd_valid ? pm_cmd_data : gb_rx_data;
    next_exec_valid = do_exec;
    next_exec_is_vout = do_exec ? ex_vout : exec_is_vout;
    next_exec_data = do_exec ? ex_data : exec_data;
    next_cmd_on = cmd_on;
    enable_rise = 1'b0;
    if (do_exec && !ex_vout)
    begin
      next_cmd_on = ex_data[gfb_pkg::OP_ON_BIT];
      enable_rise = ex_data[gfb_pkg::OP_ON_BIT] && !cmd_on;
    end
    next_ot_resp_sel = ot_resp_wr ? ot_resp_in : ot_resp_sel;
  end

  // fault shutdown and ordered restart
  always_comb
  begin
    next_fault_off = fault_off;
    next_rs_state = rs_state;
    next_rs_count = rs_count;
    case (rs_state)
      gfb_pkg::GFB_RS_IDLE:
      begin
        if (clear_faults || enable_rise)
        begin
          next_fault_off = 1'b0;
        end
      end
      gfb_pkg::GFB_RS_WAIT:
      begin
        if (rs_count <= 16'h0001)
        begin
          next_fault_off = 1'b0;
          next_rs_state = gfb_pkg::GFB_RS_IDLE;
        end
        else
        begin
          next_rs_count = rs_count - 16'h0001;
        end
      end
      default:
      begin
        next_rs_state = gfb_pkg::GFB_RS_IDLE;
      end
    endcase
    if (loc_fault || rx_fault)
    begin
      next_fault_off = 1'b1;
      next_rs_state = restart_en ? gfb_pkg::GFB_RS_WAIT :
        gfb_pkg::GFB_RS_IDLE;
      next_rs_count = 16'((32'(seq_position) * SLOT) + 1);
    end
    next_output_on = next_cmd_on && !next_fault_off && !ot_off;
  end

  // register stage
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      gb_tx_valid <= 1'b0;
      gb_tx_kind <= gfb_pkg::GB_KIND_OPERATION;
      gb_tx_data <= gfb_pkg::CMD_DATA_RESET;
      gb_tx_id <= '0;
      exec_valid <= 1'b0;
      exec_is_vout <= 1'b0;
      exec_data <= gfb_pkg::CMD_DATA_RESET;
      cmd_on <= gfb_pkg::CMD_ON_RESET;
      output_on <= 1'b0;
      fault_off <= 1'b0;
      rs_state <= gfb_pkg::GFB_RS_IDLE;
      rs_count <= 16'h0000;
      ot_resp_sel <= gfb_pkg::OT_RESP_RESET;
    end
    else if (clk_en)
    begin
      gb_tx_valid <= next_gb_tx_valid;
      gb_tx_kind <= next_gb_tx_kind;
      gb_tx_data <= next_gb_tx_data;
      gb_tx_id <= group_id;
      exec_valid <= next_exec_valid;
      exec_is_vout <= next_exec_is_vout;
      exec_data <= next_exec_data;
      cmd_on <= next_cmd_on;
      output_on <= next_output_on;
      fault_off <= next_fault_off;
      rs_state <= next_rs_state;
      rs_count <= next_rs_count;
      ot_resp_sel <= next_ot_resp_sel;
    end
  end

  // thermal monitor
  gfb_otp #(.TW(TW)) u_otp (
    .clock(clock),
    .nrst(nrst),
    .clk_en(clk_en),
    .t_ctrl(t_ctrl),
    .t_ps_a(t_ps_a),
    .t_ps_b(t_ps_b),
    .fault_limit(ot_fault_limit),
    .warn_limit(ot_warn_limit),
    .resp_auto(resp_auto_eff),
    .clear_faults(clear_faults),
    .enable_rise(enable_rise),
    .ot_off(ot_off),
    .temp1(temp1),
    .temp3(temp3)
  );

  property p_forward;
    @(posedge clock) disable iff (!nrst)
    (clk_en && pm_cmd_valid && bcast_send_en && !loc_fault &&
      !gb_tx_valid) |=> gb_tx_valid && gb_tx_data == $past(pm_cmd_data);
  endproperty
  a_forward: assert property (p_forward)
    else $error("host command not forwarded");

  property p_no_loop;
    @(posedge clock) disable iff (!nrst)
    (clk_en && gb_rx_valid && !pm_cmd_valid && !nd_fault &&
      !gb_tx_valid) |=> !gb_tx_valid;
  endproperty
  a_no_loop: assert property (p_no_loop)
    else $error("group bus command was rebroadcast");

  property p_rx_exec;
    @(posedge clock) disable iff (!nrst)
    (clk_en && rx_cmd && !pm_cmd_valid) |=>
      exec_valid && exec_data == $past(gb_rx_data);
  endproperty
  a_rx_exec: assert property (p_rx_exec)
    else $error("accepted broadcast not executed");

  property p_rx_ignore;
    @(posedge clock) disable iff (!nrst)
    (clk_en && !bcast_accept_en && !pm_cmd_valid) |=> !exec_valid;
  endproperty
  a_rx_ignore: assert property (p_rx_ignore)
    else $error("broadcast executed while accept disabled");

  sequence s_local_fault;
    clk_en && loc_fault && fault_send_en;
  endsequence
  sequence s_shut_sent;
    !output_on && gb_tx_valid && gb_tx_kind == gfb_pkg::GB_KIND_FAULT;
  endsequence
  property p_fault_spread;
    @(posedge clock) disable iff (!nrst)
    s_local_fault |=> s_shut_sent;
  endproperty
  a_fault_spread: assert property (p_fault_spread)
    else $error("local fault not shut down and sent");

  property p_follow;
    @(posedge clock) disable iff (!nrst)
    (clk_en && rx_fault) |=> !output_on && fault_off;
  endproperty
  a_follow: assert property (p_follow)
    else $error("peer fault not followed");

  sequence s_slot_end;
    clk_en && rs_state == gfb_pkg::GFB_RS_WAIT && rs_count == 16'h0001 &&
      !loc_fault && !rx_fault;
  endsequence
  property p_restart;
    @(posedge clock) disable iff (!nrst)
    s_slot_end |=> !fault_off && rs_state == gfb_pkg::GFB_RS_IDLE;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart did not occur at slot end");

  // a sharing member keeps its thermal trip even with auto selected
  property p_share_latched;
    @(posedge clock) disable iff (!nrst)
    (clk_en && current_share && ot_off && !clear_faults && !enable_rise)
      |=> ot_off;
  endproperty
  a_share_latched: assert property (p_share_latched)
    else $error("auto restart used in current sharing");
endmodule : gfb_top

// ---- verification/gfb_peer.sv ----
// group bus peer that sinks messages with random stalls
`timescale 1ns/10ps
module gfb_peer
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic tx_valid,
  input wire logic [1:0] tx_kind,
  input wire logic [4:0] tx_id,
  input wire logic [15:0] tx_data,
  output logic tx_ready,
  output logic [1:0] got_kind,
  output logic [4:0] got_id,
  output logic [15:0] got_data,
  output int got_count
);
  // ready comes and goes, so the sender must hold its message
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      tx_ready <= 1'b0;
      got_count <= 0;
    end
    else
    begin
      tx_ready <= 1'($urandom);
      // a message counts only on an edge with ready high
      if (tx_valid && tx_ready)
      begin
        got_kind <= tx_kind;
        got_id <= tx_id;
        got_data <= tx_data;
        got_count <= got_count + 1;
      end
    end
  end
endmodule : gfb_peer

// ---- verification/tb_top.sv ----
// self-checking bench of the group fault broadcast supervisor
`timescale 1ns/10ps
module tb_top;
  logic clock, nrst, clk_en, pm_cmd_valid, pm_cmd_is_vout, clear_faults;
  logic bcast_send_en, bcast_accept_en, fault_send_en, fault_follow_en;
  logic restart_en, group_id_override, nd_fault, shutdown_on_fault;
  logic current_share, ot_resp_wr, ot_resp_in, ot_resp_sel, output_on;
  logic gb_tx_valid, gb_tx_ready, gb_rx_valid, exec_valid, exec_is_vout;
  logic fault_off;
  logic [15:0] pm_cmd_data, ot_fault_limit, ot_warn_limit, t_ctrl, t_ps_a;
  logic [15:0] t_ps_b, temp1, temp3, gb_tx_data, gb_rx_data, exec_data;
  logic [15:0] p_data;
  logic [3:0] seq_position;
  logic [6:0] pm_addr;
  logic [4:0] group_id_value, group_id, gb_tx_id, gb_rx_id, p_id;
  logic [1:0] gb_tx_kind, gb_rx_kind, p_kind;
  int p_count, err_count, n_checks, cyc, i, c0, k;
  logic v, e;
  logic [15:0] d;
  // design with a short restart slot
  gfb_top #(.TW(16), .SLOT(2)) dut (.clock(clock), .nrst(nrst),
    .clk_en(clk_en), .pm_cmd_valid(pm_cmd_valid),
    .pm_cmd_is_vout(pm_cmd_is_vout), .pm_cmd_data(pm_cmd_data),
    .clear_faults(clear_faults), .bcast_send_en(bcast_send_en),
    .bcast_accept_en(bcast_accept_en), .fault_send_en(fault_send_en),
    .fault_follow_en(fault_follow_en), .restart_en(restart_en),
    .seq_position(seq_position), .pm_addr(pm_addr),
    .group_id_override(group_id_override),
    .group_id_value(group_id_value), .group_id(group_id),
    .nd_fault(nd_fault), .shutdown_on_fault(shutdown_on_fault),
    .current_share(current_share), .ot_fault_limit(ot_fault_limit),
    .ot_warn_limit(ot_warn_limit), .ot_resp_wr(ot_resp_wr),
    .ot_resp_in(ot_resp_in), .t_ctrl(t_ctrl), .t_ps_a(t_ps_a),
    .t_ps_b(t_ps_b), .ot_resp_sel(ot_resp_sel), .temp1(temp1),
    .temp3(temp3), .gb_tx_valid(gb_tx_valid), .gb_tx_ready(gb_tx_ready),
    .gb_tx_kind(gb_tx_kind), .gb_tx_id(gb_tx_id),
    .gb_tx_data(gb_tx_data), .gb_rx_valid(gb_rx_valid),
    .gb_rx_kind(gb_rx_kind), .gb_rx_id(gb_rx_id),
    .gb_rx_data(gb_rx_data), .exec_valid(exec_valid),
    .exec_is_vout(exec_is_vout), .exec_data(exec_data),
    .output_on(output_on), .fault_off(fault_off));
  // far-side peer on the group bus
  gfb_peer peer (.clock(clock), .nrst(nrst), .tx_valid(gb_tx_valid),
    .tx_kind(gb_tx_kind), .tx_id(gb_tx_id), .tx_data(gb_tx_data),
    .tx_ready(gb_tx_ready), .got_kind(p_kind), .got_id(p_id),
    .got_data(p_data), .got_count(p_count));
  // 100 MHz clock
  always #5 clock = ~clock;
  // expected group id from address and override
  function automatic logic [4:0] exp_gid(logic o, logic [4:0] val,
    logic [6:0] a);
    return o ? val : a[4:0];
  endfunction : exp_gid
  // expected hotter stage temperature
  function automatic logic [15:0] hot(logic [15:0] a, logic [15:0] b);
    return (a > b) ? a : b;
  endfunction : hot
  // compare and count
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  task automatic tk(int n);
    repeat (n) @(posedge clock);
  endtask : tk
  // host command pulse, local execution one cycle later
  task automatic host(logic vo, logic [15:0] dd);
    tk(1);
    pm_cmd_valid <= 1'b1;
    pm_cmd_is_vout <= vo;
    pm_cmd_data <= dd;
    tk(1);
    pm_cmd_valid <= 1'b0;
    pm_cmd_data <= ~dd;
    #1 chk("exec_valid", exec_valid, 1);
    chk("exec_data", exec_data, dd);
  endtask : host
  // group bus message from a peer; idle lines carry junk
  task automatic rx(logic [1:0] kk, logic [4:0] id, logic [15:0] dd);
    tk(1);
    gb_rx_valid <= 1'b1;
    gb_rx_kind <= kk;
    gb_rx_id <= id;
    gb_rx_data <= dd;
    tk(1);
    gb_rx_valid <= 1'b0;
    gb_rx_id <= ~id;
    gb_rx_data <= ~dd;
  endtask : rx
  // one-cycle pulse of clear_faults
  task automatic clr();
    tk(1);
    clear_faults <= 1'b1;
    tk(1);
    clear_faults <= 1'b0;
    tk(3);
  endtask : clr
  // hang guard
  always @(posedge clock)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      err_count++;
      finish_test();
    end
  end
  // main sequence
  initial
  begin
    clock = 0; nrst = 0; clk_en = 1; cyc = 0; err_count = 0; n_checks = 0;
    {pm_cmd_valid, pm_cmd_is_vout, clear_faults, nd_fault} = 0;
    {bcast_send_en, bcast_accept_en, fault_send_en, fault_follow_en} = 0;
    {restart_en, group_id_override, shutdown_on_fault, current_share} = 0;
    {ot_resp_wr, ot_resp_in, gb_rx_valid} = 0;
    pm_cmd_data = 0; seq_position = 0; pm_addr = 0; group_id_value = 0;
    ot_fault_limit = 16'h0100; ot_warn_limit = 16'h00C0;
    t_ctrl = 16'h0050; t_ps_a = 16'h0060; t_ps_b = 16'h0070;
    gb_rx_kind = 0; gb_rx_id = 0; gb_rx_data = 0;
    void'($urandom(32'hAF5A));
    tk(8);
    nrst <= 1'b1;
    tk(1);
    #1 chk("ot_resp_sel", ot_resp_sel, 0);
    chk("output_on", output_on, 0);
    for (i = 0; i < 8; i++)
    begin
      tk(1);
      pm_addr <= 7'($urandom);
      group_id_value <= 5'($urandom);
      group_id_override <= i[0];
      #1 chk("group_id", group_id,
        exp_gid(group_id_override, group_id_value, pm_addr));
    end
    tk(1);
    pm_addr <= 7'h55;
    group_id_override <= 1'b0;
    // host commands, forwarded only when sending is on
    for (i = 0; i < 8; i++)
    begin
      e = 1'($urandom);
      v = i[0];
      d = v ? 16'($urandom) : {8'($urandom), 8'h80};
      bcast_send_en <= e;
      c0 = p_count;
      host(v, d);
      chk("exec_is_vout", exec_is_vout, v);
      k = 0;
      while (e && p_count == c0 && k < 30)
      begin
        tk(1);
        k++;
      end
      tk(2);
      #1 chk("fwd_count", 16'(p_count - c0), 16'(e));
      if (e)
      begin
        chk("fwd_kind", p_kind, v ? 16'(gfb_pkg::GB_KIND_VOUT) :
          16'(gfb_pkg::GB_KIND_OPERATION));
        chk("fwd_data", p_data, d);
        chk("fwd_id", p_id, 16'h15);
      end
    end
    tk(2);
    #1 chk("output_on", output_on, 1);
    // group bus commands: accept enable, id match, no echo
    bcast_send_en <= 1'b1;
    for (i = 0; i < 8; i++)
    begin
      e = 1'($urandom);
      v = i[0];
      d = v ? 16'($urandom) : 16'h0080;
      bcast_accept_en <= e;
      c0 = p_count;
      rx({1'b0, v}, (i == 6) ? 5'h14 : 5'h15, d);
      #1 chk("rx_exec", exec_valid, 16'(e && i != 6));
      if (e && i != 6)
        chk("rx_data", exec_data, d);
      tk(4);
      #1 chk("no_echo", 16'(p_count - c0), 0);
    end
    // local fault with ordered restart at position two
    {fault_send_en, shutdown_on_fault, restart_en} <= 3'h7;
    seq_position <= 4'h2;
    c0 = p_count;
    tk(1);
    nd_fault <= 1'b1;
    tk(1);
    nd_fault <= 1'b0;
    #1 chk("fault_off", fault_off, 1);
    chk("output_on", output_on, 0);
    // slot end falls position times slot plus one cycles after the trip
    tk(4);
    #1 chk("restart_wait", fault_off, 1);
    tk(1);
    #1 chk("restart_done", fault_off, 0);
    chk("restart_on", output_on, 1);
    // the peer stalls at random, so wait for the fault message
    k = 0;
    while (p_count == c0 && k < 30)
    begin
      tk(1);
      k++;
    end
    tk(1);
    #1 chk("fault_msgs", 16'(p_count - c0), 1);
    chk("fault_kind", p_kind, 16'(gfb_pkg::GB_KIND_FAULT));
    chk("fault_data", p_data, 0);
    // peer fault, followed only when enabled
    restart_en <= 1'b0;
    for (i = 0; i < 2; i++)
    begin
      fault_follow_en <= i[0];
      rx(gfb_pkg::GB_KIND_FAULT, 5'h15, 16'h0000);
      #1 chk("follow", fault_off, 16'(i));
      tk(2);
      #1 chk("follow_on", output_on, 16'(i == 0));
      clr();
      #1 chk("cleared_on", output_on, 1);
    end
    // latched trip on each sensor, strict comparison at the limit
    for (i = 0; i < 3; i++)
    begin
      t_ctrl <= (i == 0) ? 16'h0100 : 16'($urandom_range(16'hBF));
      t_ps_a <= (i == 1) ? 16'h0100 : 16'($urandom_range(16'hBF));
      t_ps_b <= (i == 2) ? 16'h0100 : 16'($urandom_range(16'hBF));
      tk(3);
      #1 chk("at_limit", output_on, 1);
      chk("temp1", temp1, t_ctrl);
      chk("temp3", temp3, hot(t_ps_a, t_ps_b));
      if (i == 0) t_ctrl <= 16'h0101;
      if (i == 1) t_ps_a <= 16'h0101;
      if (i == 2) t_ps_b <= 16'h0101;
      tk(3);
      #1 chk("ot_trip", output_on, 0);
      {t_ctrl, t_ps_a, t_ps_b} <= {3{16'h0010}};
      tk(4);
      #1 chk("ot_latched", output_on, 0);
      clr();
      #1 chk("ot_clear", output_on, 1);
    end
    // auto restart with hysteresis, then current sharing forces latch
    tk(1);
    ot_resp_wr <= 1'b1;
    ot_resp_in <= gfb_pkg::OT_RESP_AUTO;
    tk(1);
    ot_resp_wr <= 1'b0;
    #1 chk("ot_resp_sel", ot_resp_sel, 1);
    for (i = 0; i < 2; i++)
    begin
      current_share <= i[0];
      t_ps_a <= 16'h0105;
      tk(3);
      #1 chk("auto_trip", output_on, 0);
      t_ps_a <= 16'h00C0;
      tk(4);
      #1 chk("auto_hyst", output_on, 0);
      t_ps_a <= 16'h00BF;
      tk(4);
      #1 chk("auto_resume", output_on, 16'(i == 0));
      clr();
    end
    #1 chk("share_clear", output_on, 1);
    // reset in mid-run brings the response back to latched
    nrst <= 1'b0;
    tk(2);
    nrst <= 1'b1;
    tk(1);
    #1 chk("ot_resp_rst", ot_resp_sel, 0);
    chk("rst_output", output_on, 0);
    finish_test();
  end
endmodule : tb_top
